/* rtl/nfc_cfg_defines.svh */
// register offsets, field positions, reset values and pulse-width figures
// assumes inclusion by bare name from the design module and the bench
`ifndef NFC_CFG_DEFINES_SVH
`define NFC_CFG_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_BIT_RATE 8'h04
`define IDX_FRAMING 8'h05
`define IDX_OP_MODE 8'h08
`define IDX_STATUS 8'h09
`define ADDR_BIT_RATE 8'h10
`define ADDR_FRAMING 8'h14
`define ADDR_OP_MODE 8'h20
`define ADDR_STATUS 8'h24

`define RST_BIT_RATE 8'h00
`define RST_FRAMING 8'h00
`define RST_OP_MODE 8'h00

// bit rate register fields
`define TX_RATE_HI 5
`define TX_RATE_LO 4
`define RX_RATE_HI 1
`define RX_RATE_LO 0

// framing register fields
`define NO_TX_PAR_BIT 7
`define NO_RX_PAR_BIT 6
`define HEADER_BIT 5
`define PLEN_HI 4
`define PLEN_LO 1
`define ANTCOLL_BIT 0

// operation mode register fields
`define TARGET_BIT 4
`define OM_HI 3
`define OM_LO 0

// pulse width base and signed step limit per rate, in carrier periods
`define PW_BASE_128 6'h23
`define PW_BASE_64 6'h12
`define PW_BASE_32 6'h09
`define PW_BASE_16 6'h05
`define PW_LIM_128 4'h8
`define PW_LIM_64 4'h6
`define PW_LIM_32 4'h4
`define PW_LIM_16 4'h3

`define OM_PT_TYPEA 4'h1
`define OM_PT_TYPEF 4'h4
`define TRANSPORT_SB 8'hF0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* rtl/nfc_cfg_pkg.sv */
// types shared by the framing configuration block
// assumes nfc_cfg_defines.svh is on the include path
`default_nettype none
package nfc_cfg_pkg;
  typedef enum logic [1:0] {
    RATE_FC128 = 2'h0,
    RATE_FC64 = 2'h1,
    RATE_FC32 = 2'h2,
    RATE_FC16 = 2'h3
  } rate_e;

  typedef struct packed {
    logic tx_parity_gen;
    logic rx_raw;
    logic tx_header_en;
    logic rx_skip_sb;
    logic antcoll;
  } framing_ctl_s;

  typedef struct packed {
    logic use_passive_drive;
    logic rate_detect_a;
    logic rate_detect_om2;
  } drive_ctl_s;
endpackage
`default_nettype wire

/* rtl/nfc_framing_cfg.sv */
// bit-rate and type A framing configuration bank behind an AXI4-Lite slave
// assumes one clock, synchronous reset, master keeps one write and one read open
//
// Notes on behaviour
// - passive target or detection uses passive drive
// - tx rate bits 5:4 select fc/128..fc/16
// - rx rate bits 1:0 same four codes
// - unsupported pulse code disables tx, unsupported raw receive disables rx
// - no tx parity, send without CRC
// - raw receive keeps parity, only 106 kbit/s
// - parity options only in reader modes
// - transport header adds F0 and length
// - pulse field bits 4:1 in carrier periods
// - fc/128 width 35 plus signed field
// - faster rates base 18/9/5, limited range
// - target with op_mode_bit3 runs rate detection
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "nfc_cfg_defines.svh"

module nfc_framing_cfg (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // axi4-lite write address and data
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  // axi4-lite write response
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // axi4-lite read
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // requests from the sequencer
  input wire logic tx_req_in,
  input wire logic rx_req_in,
  // decoded settings to the coder and front end
  output nfc_cfg_pkg::rate_e tx_rate_out,
  output nfc_cfg_pkg::rate_e rx_rate_out,
  output logic tx_en_out,
  output logic rx_en_out,
  output logic [5:0] pulse_width_out,
  output nfc_cfg_pkg::framing_ctl_s framing_out,
  output nfc_cfg_pkg::drive_ctl_s drive_out
);

  // configuration storage, reserved bits are not stored at all
  logic [1:0] tx_rate_ff, nxt_tx_rate;
  logic [1:0] rx_rate_ff, nxt_rx_rate;
  logic [7:0] framing_ff, nxt_framing;
  logic [4:0] op_mode_ff, nxt_op_mode;

  // bus handshake state
  logic aw_held_ff, nxt_aw_held;
  logic w_held_ff, nxt_w_held;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic w_strb0_ff, nxt_w_strb0;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  // registered outputs
  logic tx_en_ff, nxt_tx_en;
  logic rx_en_ff, nxt_rx_en;
  logic [5:0] pw_ff, nxt_pw;
  nfc_cfg_pkg::framing_ctl_s fr_ff, nxt_fr;
  nfc_cfg_pkg::drive_ctl_s dr_ff, nxt_dr;

  // decoded mode
  logic target, detect_mode, passive_target, reader;
  logic signed [4:0] plen_s;
  logic [3:0] plen_mag;
  logic [5:0] pw_base;
  logic [3:0] pw_lim;
  logic pulse_ok, raw_ok;
  logic wr_go;
  logic awready_ff, wready_ff, arready_ff;
  logic nxt_awready, nxt_wready, nxt_arready;

  always_comb begin
    target = op_mode_ff[`TARGET_BIT];
    detect_mode = target & op_mode_ff[`OM_HI];
    passive_target = target & ((op_mode_ff[`OM_HI:`OM_LO] == `OM_PT_TYPEA) |
                               (op_mode_ff[`OM_HI:`OM_LO] == `OM_PT_TYPEF));
    reader = ~target;
    plen_s = 5'(signed'(framing_ff[`PLEN_HI:`PLEN_LO]));
    plen_mag = plen_s[4] ? 4'(-plen_s) : plen_s[3:0];
    unique case (nfc_cfg_pkg::rate_e'(tx_rate_ff))
      nfc_cfg_pkg::RATE_FC128: begin
        pw_base = `PW_BASE_128;
        pw_lim = `PW_LIM_128;
      end
      nfc_cfg_pkg::RATE_FC64: begin
        pw_base = `PW_BASE_64;
        pw_lim = `PW_LIM_64;
      end
      nfc_cfg_pkg::RATE_FC32: begin
        pw_base = `PW_BASE_32;
        pw_lim = `PW_LIM_32;
      end
      nfc_cfg_pkg::RATE_FC16: begin
        pw_base = `PW_BASE_16;
        pw_lim = `PW_LIM_16;
      end
    endcase
    // undefined pulse codes leave no safe waveform, so tx stops
    pulse_ok = (plen_mag <= pw_lim) & ~(plen_s == -5'sd8 && tx_rate_ff != 2'h0);
    // raw receive outside 106 kbit/s is unsupported
    raw_ok = ~(framing_ff[`NO_RX_PAR_BIT] & reader & (rx_rate_ff != 2'h0));
  end

  // outputs follow the stored settings one cycle later
  always_comb begin
    nxt_pw = 6'(pw_base + 6'(plen_s));
    nxt_tx_en = tx_req_in & pulse_ok;
    nxt_rx_en = rx_req_in & raw_ok;
    nxt_fr.tx_parity_gen = ~(framing_ff[`NO_TX_PAR_BIT] & reader);
    nxt_fr.rx_raw = framing_ff[`NO_RX_PAR_BIT] & reader & raw_ok;
    // header is forced off in detection, protecting against a bad setting
    nxt_fr.tx_header_en = framing_ff[`HEADER_BIT] & ~detect_mode;
    nxt_fr.rx_skip_sb = framing_ff[`HEADER_BIT] & ~detect_mode;
    nxt_fr.antcoll = framing_ff[`ANTCOLL_BIT];
    nxt_dr.use_passive_drive = passive_target | detect_mode;
    nxt_dr.rate_detect_a = detect_mode & op_mode_ff[0];
    nxt_dr.rate_detect_om2 = detect_mode & op_mode_ff[2];
  end

  // write channel: address and data taken in either order
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb0 = w_strb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_tx_rate = tx_rate_ff;
    nxt_rx_rate = rx_rate_ff;
    nxt_framing = framing_ff;
    nxt_op_mode = op_mode_ff;
    wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;
    if (awvalid_in && !aw_held_ff) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = awaddr_in;
    end
    if (wvalid_in && !w_held_ff) begin
      nxt_w_held = 1'b1;
      nxt_w_data = wdata_in;
      nxt_w_strb0 = wstrb_in[0];
    end
    if (bvalid_ff && bready_in) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `RESP_OKAY;
      unique case (aw_addr_ff)
        `ADDR_BIT_RATE: begin
          if (w_strb0_ff) begin
            nxt_tx_rate = w_data_ff[`TX_RATE_HI:`TX_RATE_LO];
            nxt_rx_rate = w_data_ff[`RX_RATE_HI:`RX_RATE_LO];
          end
        end
        `ADDR_FRAMING: begin
          if (w_strb0_ff) begin
            nxt_framing = w_data_ff[7:0];
          end
        end
        `ADDR_OP_MODE: begin
          if (w_strb0_ff) begin
            nxt_op_mode = w_data_ff[4:0];
          end
        end
        `ADDR_STATUS: begin
          nxt_bresp = `RESP_OKAY;
        end
        default: begin
          nxt_bresp = `RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = ~nxt_aw_held;
    nxt_wready = ~nxt_w_held;
  end

  // read channel; upper and reserved bits read as zero
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && rready_in) begin
      nxt_rvalid = 1'b0;
    end
    if (arvalid_in && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `RESP_OKAY;
      unique case (araddr_in)
        `ADDR_BIT_RATE: nxt_rdata = {26'h0, tx_rate_ff, 2'h0, rx_rate_ff};
        `ADDR_FRAMING: nxt_rdata = {24'h0, framing_ff};
        `ADDR_OP_MODE: nxt_rdata = {27'h0, op_mode_ff};
        `ADDR_STATUS: nxt_rdata = {21'h0, pulse_ok, raw_ok, tx_en_ff, rx_en_ff,
                                   detect_mode, pw_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = `RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = ~nxt_rvalid;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_rate_ff <= 2'(`RST_BIT_RATE >> `TX_RATE_LO);
      rx_rate_ff <= 2'(`RST_BIT_RATE >> `RX_RATE_LO);
      framing_ff <= `RST_FRAMING;
      op_mode_ff <= 5'(`RST_OP_MODE);
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
      pw_ff <= `PW_BASE_128;
      fr_ff <= 5'h10;
      dr_ff <= 3'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
    end else begin
      tx_rate_ff <= nxt_tx_rate;
      rx_rate_ff <= nxt_rx_rate;
      framing_ff <= nxt_framing;
      op_mode_ff <= nxt_op_mode;
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb0_ff <= nxt_w_strb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      tx_en_ff <= nxt_tx_en;
      rx_en_ff <= nxt_rx_en;
      pw_ff <= nxt_pw;
      fr_ff <= nxt_fr;
      dr_ff <= nxt_dr;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
    end
  end

  assign awready_out = awready_ff;
  assign wready_out = wready_ff;
  assign bvalid_out = bvalid_ff;
  assign bresp_out = bresp_ff;
  assign arready_out = arready_ff;
  assign rvalid_out = rvalid_ff;
  assign rdata_out = rdata_ff;
  assign rresp_out = rresp_ff;
  assign tx_rate_out = nfc_cfg_pkg::rate_e'(tx_rate_ff);
  assign rx_rate_out = nfc_cfg_pkg::rate_e'(rx_rate_ff);
  assign tx_en_out = tx_en_ff;
  assign rx_en_out = rx_en_ff;
  assign pulse_width_out = pw_ff;
  assign framing_out = fr_ff;
  assign drive_out = dr_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_tx_rate_store: assert property (
    wr_go && aw_addr_ff == `ADDR_BIT_RATE && w_strb0_ff
    |=> tx_rate_ff == $past(w_data_ff[5:4]) ##1 tx_rate_out == $past(w_data_ff[5:4], 2))
    else $error("tx rate field not taken from bits 5:4");
  a_rx_rate_store: assert property (
    wr_go && aw_addr_ff == `ADDR_BIT_RATE && w_strb0_ff
    |=> ##1 rx_rate_out == $past(w_data_ff[1:0], 2))
    else $error("rx rate field not taken from bits 1:0");
  a_bad_pulse_off: assert property (
    !pulse_ok |=> !tx_en_out)
    else $error("tx enabled with undefined pulse code");
  a_card_keeps_par: assert property (
    target && $stable(target) |=> framing_out.tx_parity_gen && !framing_out.rx_raw)
    else $error("parity option active in card emulation");
  a_raw_only_106: assert property (
    framing_out.rx_raw |-> rx_rate_out == nfc_cfg_pkg::RATE_FC128 || $changed(rx_rate_out))
    else $error("raw receive outside 106 kbit/s");
  a_header_follow: assert property (
    framing_ff[5] && !detect_mode |=> framing_out.tx_header_en && framing_out.rx_skip_sb)
    else $error("transport header not applied");
  a_pulse_fc128: assert property (
    tx_rate_ff == 2'h0 |=> pulse_width_out == 6'($past(6'd35 + 6'(plen_s))))
    else $error("fc/128 pulse width wrong");
  a_pulse_fast: assert property (
    tx_rate_ff == 2'h3 && framing_ff[4:1] == 4'h0 |=> pulse_width_out == 6'd5)
    else $error("fc/16 base pulse width wrong");
  a_passive_drive: assert property (
    detect_mode |=> drive_out.use_passive_drive)
    else $error("detection without passive drive");
  a_reset_zero: assert property (@(posedge clk_in) disable iff (1'b0)
    rst_in |=> tx_rate_ff == 2'h0 && rx_rate_ff == 2'h0 && framing_ff == 8'h00)
    else $error("config not zero after reset");
  a_reserved_zero: assert property (
    arvalid_in && arready_out && araddr_in == `ADDR_BIT_RATE
    |=> rdata_out[7:6] == 2'h0 && rdata_out[3:2] == 2'h0 && rvalid_out)
    else $error("reserved rate bits read nonzero");
endmodule

`default_nettype wire

/* verification/rf_peer_model.sv */
// far-side stand-in that raises frame requests toward the config bank
// assumes the bank's clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module rf_peer_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // bench control
  input wire logic want_in,
  // frame requests, held as levels for the whole frame
  output logic tx_req_out,
  output logic rx_req_out
);
  logic req_ff;
  logic nxt_req;

  // registered so requests never change in the edge that samples them
  always_comb nxt_req = want_in & ~rst_in;
  always_ff @(posedge clk_in) req_ff <= nxt_req;
  assign tx_req_out = req_ff;
  assign rx_req_out = req_ff;
endmodule

`default_nettype wire

/* verification/nfc_bitrate_and_typea_framing_cfg_bench.sv */
// self-checking bench for the bit-rate and type A framing config bank
// assumes package, defines header and the rf peer model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "nfc_cfg_defines.svh"

module nfc_bitrate_and_typea_framing_cfg_bench;
  logic clk_in, rst_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in, want;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, tx_en_out, rx_en_out;
  logic [7:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [3:0] wstrb_in;
  logic [1:0] bresp_out, rresp_out;
  logic [5:0] pulse_width_out;
  nfc_cfg_pkg::rate_e tx_rate_out, rx_rate_out;
  nfc_cfg_pkg::framing_ctl_s framing_out;
  nfc_cfg_pkg::drive_ctl_s drive_out;
  wire logic tx_req, rx_req;
  logic [34:0] exp_q[$];
  int n_mismatch, checked;

  nfc_framing_cfg uut (.clk_in, .rst_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in,
    .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in,
    .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
    .tx_req_in(tx_req), .rx_req_in(rx_req), .tx_rate_out, .rx_rate_out, .tx_en_out,
    .rx_en_out, .pulse_width_out, .framing_out, .drive_out);

  rf_peer_model peer (.clk_in, .rst_in, .want_in(want), .tx_req_out(tx_req),
    .rx_req_out(rx_req));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic check(input string n, input logic [34:0] e, input logic [34:0] s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // readies sampled mid-cycle, where they stand for the coming edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk_in);
    exp_q.push_back({1'b0, r, 32'h0000_0000});
    awaddr_in <= a;
    wdata_in <= {24'h00_0000, d};
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clk_in);
      aw_ok = awvalid_in && awready_out;
      w_ok = wvalid_in && wready_out;
      b_ok = bvalid_out;
      @(posedge clk_in);
      if (aw_ok) awvalid_in <= 1'b0;
      if (w_ok) wvalid_in <= 1'b0;
    end
    bready_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar_ok, r_ok;
    @(posedge clk_in);
    exp_q.push_back({1'b1, r, d});
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge clk_in);
      ar_ok = arvalid_in && arready_out;
      r_ok = rvalid_out;
      @(posedge clk_in);
      if (ar_ok) arvalid_in <= 1'b0;
    end
    rready_in <= 1'b0;
  endtask

  task automatic pop_cmp(input string n, input logic [34:0] s);
    if (exp_q.size() == 0) check(n, 35'h0, ~s);
    else check(n, exp_q.pop_front(), s);
  endtask

  // monitor: each bus answer is paired with the oldest note, read mid-cycle
  always @(negedge clk_in) begin
    if (bvalid_out && bready_in) pop_cmp("write response", {1'b0, bresp_out, 32'h0000_0000});
    if (rvalid_out && rready_in) pop_cmp("read response", {1'b1, rresp_out, rdata_out});
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    stop_test();
  end

  initial begin
    logic [7:0] f;
    logic ok;
    int s;
    int base[4] = '{35, 18, 9, 5};
    int lim[4] = '{8, 6, 4, 3};
    logic [7:0] ops[4] = '{8'h11, 8'h14, 8'h1D, 8'h18};
    logic [2:0] drv[4] = '{3'h4, 3'h4, 3'h7, 3'h4};
    rst_in = 1'b1;
    {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in, want} = 6'h00;
    awaddr_in = 8'h00;
    araddr_in = 8'h00;
    wdata_in = 32'h0000_0000;
    wstrb_in = 4'hF;
    void'($urandom(81));
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    want <= 1'b1;
    rd(`ADDR_BIT_RATE, 32'h0000_0000, `RESP_OKAY);
    rd(`ADDR_FRAMING, 32'h0000_0000, `RESP_OKAY);
    check("reset pulse width", 35'(6'h23), 35'(pulse_width_out));
    for (int t = 0; t < 4; t++) begin
      for (int r = 0; r < 4; r++) begin
        wr(`ADDR_BIT_RATE, 8'(t * 16 + r + 8'hCC), `RESP_OKAY);
        rd(`ADDR_BIT_RATE, 32'(t * 16 + r), `RESP_OKAY);
        repeat (3) @(posedge clk_in);
        check("tx rate", 35'(t), 35'(tx_rate_out));
        check("rx rate", 35'(r), 35'(rx_rate_out));
      end
    end
    // every pulse code at every rate, other framing bits random
    for (int rt = 0; rt < 4; rt++) begin
      wr(`ADDR_BIT_RATE, 8'(rt * 17), `RESP_OKAY);
      for (int c = 0; c < 16; c++) begin
        f = {3'($urandom), 4'(c), 1'($urandom)};
        s = c > 7 ? c - 16 : c;
        ok = rt == 0 || (s <= lim[rt] && s >= -lim[rt]);
        wr(`ADDR_FRAMING, f, `RESP_OKAY);
        rd(`ADDR_FRAMING, {24'h00_0000, f}, `RESP_OKAY);
        repeat (3) @(posedge clk_in);
        check("tx enable", 35'(ok), 35'(tx_en_out));
        check("rx enable", 35'(!(f[6] && rt != 0)), 35'(rx_en_out));
        if (ok) check("pulse width", 35'(base[rt] + s), 35'(pulse_width_out));
        check("framing", 35'({~f[7], f[6] && rt == 0, f[5], f[5], f[0]}), 35'(framing_out));
      end
    end
    // parity options are ignored in both passive target modes and in two detection modes
    wr(`ADDR_FRAMING, 8'hC0, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_OP_MODE, ops[i], `RESP_OKAY);
      repeat (3) @(posedge clk_in);
      check("drive select", 35'(drv[i]), 35'(drive_out));
      check("target framing", 35'h0_0000_0010, 35'(framing_out));
      check("target rx enable", 35'h1, 35'(rx_en_out));
    end
    wr(8'h30, 8'hFF, `RESP_SLVERR);
    rd(8'h30, 32'h0000_0000, `RESP_SLVERR);
    rd(`ADDR_OP_MODE, 32'h0000_0018, `RESP_OKAY);
    wr(`ADDR_STATUS, 8'hFF, `RESP_OKAY);
    rd(`ADDR_STATUS, 32'h0000_07C5, `RESP_OKAY);
    // a cleared byte strobe must leave the register alone
    wstrb_in <= 4'hE;
    wr(`ADDR_FRAMING, 8'h00, `RESP_OKAY);
    wstrb_in <= 4'hF;
    rd(`ADDR_FRAMING, 32'h0000_00C0, `RESP_OKAY);
    // second reset with nonzero settings in place
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`ADDR_BIT_RATE, 32'h0000_0000, `RESP_OKAY);
    rd(`ADDR_FRAMING, 32'h0000_0000, `RESP_OKAY);
    rd(`ADDR_OP_MODE, 32'h0000_0000, `RESP_OKAY);
    check("reset pulse width again", 35'(6'h23), 35'(pulse_width_out));
    repeat (4) @(posedge clk_in);
    stop_test();
  end
endmodule

`default_nettype wire
